// file: rtl/dbg_cmp_ext_pkg.sv
// package: register map, field positions and reset values of the comparator extension block
package dbg_cmp_ext_pkg;
  localparam logic [3:0] OFS_CMP_A_EXT  = 4'h8;
  localparam logic [3:0] OFS_CMP_B_EXT  = 4'h9;
  localparam logic [3:0] OFS_CMP_A_ADDR = 4'h0;
  localparam logic [3:0] OFS_CMP_B_ADDR = 4'h2;
  localparam logic [3:0] OFS_MODE       = 4'hC;
  localparam int         BIT_DIR_EN     = 7;
  localparam int         BIT_DIR_VAL    = 6;
  localparam int         BIT_PAGE_SEL   = 5;
  localparam int         BIT_ADDR16     = 0;
  localparam logic [7:0] EXT_WMASK      = 8'hE1;
  localparam logic [7:0] EXT_RESET      = 8'h00;
  localparam logic [15:0] ADDR_RESET    = 16'h0000;
  localparam int         MODE_FULL_BIT  = 0;
  localparam int         MODE_DEBUGGER_ENABLE_BIT = 1;
  localparam int         MODE_BEGIN_BIT = 2;
  localparam logic [2:0] MODE_RESET     = 3'h0;
endpackage

// file: rtl/dbg_cmp_ext.sv
// comparator extension qualification logic with a classic wishbone register slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module dbg_cmp_ext
  import dbg_cmp_ext_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic [15:0]       CORE_ADDR,
  input  wire logic [16:0]       LINEAR_ADDR,
  input  wire logic              LINEAR_SEL,
  input  wire logic [7:0]        CORE_DATA,
  input  wire logic              CORE_READ,
  input  wire logic              CORE_VALID,
  input  wire logic              PAGED_ACCESS,
  input  wire logic [2:0]        PROGRAM_PAGE,
  input  wire logic              END_TRACE_RESET,
  output logic                   MATCH_A,
  output logic                   MATCH_B,
  output logic [16:0]            COMPARED_ADDR
);
  import dbg_cmp_ext_pkg::*;

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0]  ext_a_q, ext_a_d, ext_b_q, ext_b_d;
  logic [15:0] addr_a_q, addr_a_d, addr_b_q, addr_b_d;
  logic [2:0]  mode_q, mode_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic        keep_ext;
  logic        req;
  logic        wr;

  assign req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr  = req && WB_WE_I && WB_SEL_I[0];
  // debug enabled and trigger-at-start clear: extension contents survive an end-trace reset
  assign keep_ext = END_TRACE_RESET && mode_q[MODE_DEBUGGER_ENABLE_BIT] && !mode_q[MODE_BEGIN_BIT];

  function automatic logic [7:0] wr_ext(input logic [7:0] cur, input logic [7:0] wd);
    wr_ext = (cur & ~EXT_WMASK) | (wd & EXT_WMASK);
  endfunction

  always_comb
  begin
    ext_a_d  = ext_a_q;
    ext_b_d  = ext_b_q;
    addr_a_d = addr_a_q;
    addr_b_d = addr_b_q;
    mode_d   = mode_q;
    ack_d    = req;
    rdata_d  = rdata_q;
    if (wr)
    begin
      unique case (WB_ADR_I)
        OFS_CMP_A_EXT:  ext_a_d = wr_ext(ext_a_q, WB_DAT_I[7:0]);
        OFS_CMP_B_EXT:  ext_b_d = wr_ext(ext_b_q, WB_DAT_I[7:0]);
        OFS_CMP_A_ADDR: addr_a_d = WB_SEL_I[1] ? WB_DAT_I[15:0] : {addr_a_q[15:8], WB_DAT_I[7:0]};
        OFS_CMP_B_ADDR: addr_b_d = WB_SEL_I[1] ? WB_DAT_I[15:0] : {addr_b_q[15:8], WB_DAT_I[7:0]};
        OFS_MODE:       mode_d = WB_DAT_I[2:0];
        default:        mode_d = mode_q;
      endcase
    end
    if (req && !WB_WE_I)
    begin
      unique case (WB_ADR_I)
        OFS_CMP_A_EXT:  rdata_d = {24'h00_0000, ext_a_q};
        OFS_CMP_B_EXT:  rdata_d = {24'h00_0000, ext_b_q};
        OFS_CMP_A_ADDR: rdata_d = {16'h0000, addr_a_q};
        OFS_CMP_B_ADDR: rdata_d = {16'h0000, addr_b_q};
        OFS_MODE:       rdata_d = {29'h0000_0000, mode_q};
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      if (!keep_ext)
      begin
        ext_a_q  <= EXT_RESET;
        ext_b_q  <= EXT_RESET;
        addr_a_q <= ADDR_RESET;
        addr_b_q <= ADDR_RESET;
      end
      mode_q  <= MODE_RESET;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ext_a_q  <= ext_a_d;
      ext_b_q  <= ext_b_d;
      addr_a_q <= addr_a_d;
      addr_b_q <= addr_b_d;
      mode_q   <= mode_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

  // ************************************************************
  // qualification
  // ************************************************************
  logic [16:0] cmp_addr;
  logic        full_mode;
  logic        a_ok, b_ok, b_dir_en, b_dir_val;
  logic        ma_d, mb_d, ma_q, mb_q;
  logic [16:0] ca_q;

  assign full_mode = mode_q[MODE_FULL_BIT];

  always_comb
  begin
    if (PAGED_ACCESS)
      cmp_addr = {PROGRAM_PAGE, CORE_ADDR[13:0]};
    else if (LINEAR_SEL)
      cmp_addr = LINEAR_ADDR;
    else
      cmp_addr = {1'b0, CORE_ADDR};
  end

  function automatic logic dir_ok(input logic en, input logic val, input logic rd);
    dir_ok = !en || (val == rd);
  endfunction

  // in full mode B borrows A's direction bits, its own are dead
  assign b_dir_en  = full_mode ? ext_a_q[BIT_DIR_EN]  : ext_b_q[BIT_DIR_EN];
  assign b_dir_val = full_mode ? ext_a_q[BIT_DIR_VAL] : ext_b_q[BIT_DIR_VAL];

  always_comb
  begin
    a_ok = dir_ok(ext_a_q[BIT_DIR_EN], ext_a_q[BIT_DIR_VAL], CORE_READ)
           && (ext_a_q[BIT_PAGE_SEL] == PAGED_ACCESS)
           && (ext_a_q[BIT_ADDR16] == cmp_addr[16])
           && (addr_a_q == cmp_addr[15:0]);
    if (full_mode)
      b_ok = dir_ok(b_dir_en, b_dir_val, CORE_READ) && (addr_b_q[7:0] == CORE_DATA);
    else
      b_ok = dir_ok(b_dir_en, b_dir_val, CORE_READ)
             && (ext_b_q[BIT_PAGE_SEL] == PAGED_ACCESS)
             && (ext_b_q[BIT_ADDR16] == cmp_addr[16])
             && (addr_b_q == cmp_addr[15:0]);
    ma_d = CORE_VALID && a_ok;
    mb_d = CORE_VALID && b_ok;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ma_q <= 1'b0;
      mb_q <= 1'b0;
      ca_q <= 17'h0_0000;
    end
    else
    begin
      ma_q <= ma_d;
      mb_q <= mb_d;
      ca_q <= cmp_addr;
    end
  end

  assign MATCH_A       = ma_q;
  assign MATCH_B       = mb_q;
  assign COMPARED_ADDR = ca_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_dir_a_write: assert property (@(posedge CLOCK) disable iff (RST)
    (CORE_VALID && ext_a_q[7] && !ext_a_q[6] && CORE_READ) |=> !MATCH_A)
    else $error("comparator a matched a read while set for writes");
  a_dir_a_off: assert property (@(posedge CLOCK) disable iff (RST)
    (CORE_VALID && !ext_a_q[7] && a_ok) |=> MATCH_A)
    else $error("comparator a missed with direction ignored");
  a_page_a_qual: assert property (@(posedge CLOCK) disable iff (RST)
    MATCH_A |-> $past(ext_a_q[5]) == $past(PAGED_ACCESS))
    else $error("comparator a page qualifier violated");
  a_paged_addr: assert property (@(posedge CLOCK) disable iff (RST)
    PAGED_ACCESS |=> COMPARED_ADDR == {$past(PROGRAM_PAGE), $past(CORE_ADDR[13:0])})
    else $error("paged compare address wrong");
  a_cpu_addr: assert property (@(posedge CLOCK) disable iff (RST)
    (!PAGED_ACCESS && !LINEAR_SEL) |=> !COMPARED_ADDR[16])
    else $error("cpu address bit 16 not zero");
  a_bit16_a: assert property (@(posedge CLOCK) disable iff (RST)
    MATCH_A |-> $past(ext_a_q[0]) == $past(cmp_addr[16]))
    else $error("comparator a bit 16 mismatch");
  a_b_dir_full: assert property (@(posedge CLOCK) disable iff (RST)
    (full_mode && CORE_VALID && ext_a_q[7] && (ext_a_q[6] != CORE_READ)) |=> !MATCH_B)
    else $error("comparator b ignored a direction in full mode");
  a_b_dir_own: assert property (@(posedge CLOCK) disable iff (RST)
    (!full_mode && CORE_VALID && ext_b_q[7] && (ext_b_q[6] != CORE_READ)) |=> !MATCH_B)
    else $error("comparator b ignored own direction");
  a_b_page_own: assert property (@(posedge CLOCK) disable iff (RST)
    (MATCH_B && !$past(full_mode)) |-> $past(ext_b_q[5]) == $past(PAGED_ACCESS))
    else $error("comparator b page qualifier violated");
  a_b_bit16_own: assert property (@(posedge CLOCK) disable iff (RST)
    (MATCH_B && !$past(full_mode)) |-> $past(ext_b_q[0]) == $past(cmp_addr[16]))
    else $error("comparator b bit 16 mismatch");
  a_b_data_full: assert property (@(posedge CLOCK) disable iff (RST)
    (MATCH_B && $past(full_mode)) |-> $past(addr_b_q[7:0]) == $past(CORE_DATA))
    else $error("comparator b data mismatch in full mode");
  a_b_full_free: assert property (@(posedge CLOCK) disable iff (RST)
    (full_mode && CORE_VALID && !ext_a_q[7] && addr_b_q[7:0] == CORE_DATA) |=> MATCH_B)
    else $error("comparator b used page or bit 16 in full mode");
  a_match_valid: assert property (@(posedge CLOCK) disable iff (RST)
    (MATCH_A || MATCH_B) |-> $past(CORE_VALID))
    else $error("match without a bus cycle");
  a_keep_ext: assert property (@(posedge CLOCK)
    (RST && keep_ext) |=> $stable(ext_a_q) && $stable(ext_b_q))
    else $error("extension registers lost on end-trace reset");

  // ************************************************************
  // bus and reset checks
  // ************************************************************
  a_ack_pulse: assert property (@(posedge CLOCK) disable iff (RST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (@(posedge CLOCK) disable iff (RST)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("request not answered in one cycle");
  a_ack_needs_req: assert property (@(posedge CLOCK) disable iff (RST)
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (RST)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h5) |=> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ext_a_rsvd: assert property (@(posedge CLOCK) disable iff (RST)
    (ext_a_q & ~EXT_WMASK) == 8'h00)
    else $error("reserved bits of extension a set");
  a_ext_b_rsvd: assert property (@(posedge CLOCK) disable iff (RST)
    (ext_b_q & ~EXT_WMASK) == 8'h00)
    else $error("reserved bits of extension b set");
  // plain resets must clear; only the armed end-trace reset may keep
  a_ext_reset: assert property (@(posedge CLOCK)
    (RST && !keep_ext) |=> (ext_a_q == EXT_RESET) && (ext_b_q == EXT_RESET))
    else $error("extension registers not cleared by reset");
  a_addr_keep: assert property (@(posedge CLOCK)
    (RST && keep_ext) |=> $stable(addr_a_q) && $stable(addr_b_q))
    else $error("compare addresses lost on end-trace reset");
  a_mode_reset: assert property (@(posedge CLOCK)
    RST |=> mode_q == MODE_RESET)
    else $error("mode not cleared by reset");
  a_match_reset: assert property (@(posedge CLOCK)
    RST |=> !MATCH_A && !MATCH_B && COMPARED_ADDR == 17'h0_0000)
    else $error("outputs not cleared by reset");

  // ************************************************************
  // qualification checks
  // ************************************************************
  a_dir_a_read: assert property (@(posedge CLOCK) disable iff (RST)
    (CORE_VALID && ext_a_q[BIT_DIR_EN] && ext_a_q[BIT_DIR_VAL] && !CORE_READ) |=> !MATCH_A)
    else $error("comparator a matched a write while set for reads");
  a_linear_addr: assert property (@(posedge CLOCK) disable iff (RST)
    (!PAGED_ACCESS && LINEAR_SEL) |=> COMPARED_ADDR == $past(LINEAR_ADDR))
    else $error("linear compare address wrong");
  a_cpu_low: assert property (@(posedge CLOCK) disable iff (RST)
    (!PAGED_ACCESS && !LINEAR_SEL) |=> COMPARED_ADDR[15:0] == $past(CORE_ADDR))
    else $error("cpu compare address wrong");
  a_a_hit: assert property (@(posedge CLOCK) disable iff (RST)
    (CORE_VALID && a_ok) |=> MATCH_A)
    else $error("comparator a missed a qualified cycle");
  a_b_own_hit: assert property (@(posedge CLOCK) disable iff (RST)
    (!full_mode && CORE_VALID && b_ok) |=> MATCH_B)
    else $error("comparator b missed a qualified cycle");
  a_no_valid: assert property (@(posedge CLOCK) disable iff (RST)
    !CORE_VALID |=> !MATCH_A && !MATCH_B)
    else $error("match raised on an idle bus");
  a_b_data_miss: assert property (@(posedge CLOCK) disable iff (RST)
    (full_mode && CORE_VALID && addr_b_q[7:0] != CORE_DATA) |=> !MATCH_B)
    else $error("comparator b matched wrong data in full mode");
  a_a_page_miss: assert property (@(posedge CLOCK) disable iff (RST)
    (CORE_VALID && ext_a_q[BIT_PAGE_SEL] != PAGED_ACCESS) |=> !MATCH_A)
    else $error("comparator a matched the wrong page kind");
endmodule
`default_nettype wire

// file: testbench/core_bus_model.sv
// core bus model: random bus cycles, biased toward the armed compare target
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  input  wire logic        clk,
  input  wire logic [16:0] tgt,
  output logic      [15:0] addr,
  output logic      [16:0] lin,
  output logic             lsel,
  output logic      [7:0]  data,
  output logic             rd,
  output logic             vld,
  output logic             paged,
  output logic      [2:0]  page
);
  logic [31:0] r;
  // half the cycles aim at the target, so hits and near misses both occur
  always @(posedge clk)
  begin
    r = $urandom;
    addr  <= r[0] ? tgt[15:0] : 16'($urandom);
    page  <= r[1] ? tgt[16:14] : r[10:8];
    lin   <= r[2] ? tgt : 17'($urandom);
    data  <= r[3] ? tgt[7:0] : r[23:16];
    rd    <= r[4];
    vld   <= r[5] | r[6];
    paged <= r[7];
    lsel  <= r[11];
  end
endmodule
`default_nettype wire

// file: testbench/dbg_cmp_ext_test.sv
// testbench: reference model of both comparators checked every cycle outside reset and register accesses, plus register and reset checks
`timescale 1ns/1ps
`default_nettype none
module dbg_cmp_ext_test;
  import dbg_cmp_ext_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, etr = 0, busy = 1, ok_q = 0;
  logic        lsel, rd, vld, pg, ma, mb, ack, exp_a, exp_b;
  logic [3:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, dat_o;
  logic [15:0] caddr, aa = 0, ab = 0;
  logic [16:0] lin, cmp, exp_c, tgt = 0;
  logic [7:0]  cdat, ea = 0, eb = 0;
  logic [2:0]  page, md = 0;
  int          error_cnt = 0, checks_done = 0;
  initial forever #2 clk = ~clk;
  dbg_cmp_ext dbg_cmp_ext_i (.CLOCK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CORE_ADDR(caddr),
    .LINEAR_ADDR(lin), .LINEAR_SEL(lsel), .CORE_DATA(cdat), .CORE_READ(rd), .CORE_VALID(vld),
    .PAGED_ACCESS(pg), .PROGRAM_PAGE(page), .END_TRACE_RESET(etr), .MATCH_A(ma), .MATCH_B(mb),
    .COMPARED_ADDR(cmp));
  core_bus_model core_bus_model_i (.clk(clk), .tgt(tgt), .addr(caddr), .lin(lin), .lsel(lsel),
    .data(cdat), .rd(rd), .vld(vld), .paged(pg), .page(page));
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    checks_done++;
    if (e !== g)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one classic cycle; no latency assumed, only the bounded wait for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    busy = 1;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 0; stb <= 0;
    if (n >= 50)
    begin
      error_cnt++;
      give_verdict;
    end
    @(posedge clk);
    busy = 0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1, a, d);
    case (a)
      OFS_CMP_A_EXT:  ea = d[7:0] & EXT_WMASK;
      OFS_CMP_B_EXT:  eb = d[7:0] & EXT_WMASK;
      OFS_CMP_A_ADDR: aa = d[15:0];
      OFS_CMP_B_ADDR: ab = d[15:0];
      OFS_MODE:       md = d[2:0];
      default: ;
    endcase
  endtask
  task automatic rchk(input logic [3:0] a, input logic [16:0] e);
    wb(0, a, 32'h0000_0000);
    chk("register", e, rdat[16:0]);
  endtask
  // reference model, taken from the inputs the design samples at this edge
  always @(posedge clk)
  begin : model
    logic [16:0] c;
    logic        dira;
    c = pg ? {page, caddr[13:0]} : (lsel ? lin : {1'b0, caddr});
    dira = !ea[7] || (rd == ea[6]);
    exp_c <= c;
    exp_a <= vld && dira && c == {ea[0], aa} && pg == ea[5];
    exp_b <= md[MODE_FULL_BIT] ? vld && dira && cdat == ab[7:0]
           : vld && (!eb[7] || rd == eb[6]) && c == {eb[0], ab} && pg == eb[5];
    ok_q <= !busy && !rst;
  end
  always @(negedge clk)
    if (ok_q)
    begin
      chk("match_a", exp_a, ma);
      chk("match_b", exp_b, mb);
      chk("cmp_addr", exp_c, cmp);
    end
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    logic k;
    void'($urandom(77));
    repeat (2) @(posedge clk);
    rst <= 0;
    busy = 0;
    wr(4'h5, 32'hFFFF_FFFF);
    rchk(4'h5, 17'h0_0000);
    for (int i = 0; i < 60; i++)
    begin
      wr(OFS_CMP_A_EXT, $urandom);
      wr(OFS_CMP_B_EXT, $urandom);
      wr(OFS_CMP_A_ADDR, $urandom);
      wr(OFS_CMP_B_ADDR, $urandom);
      wr(OFS_MODE, $urandom);
      rchk(OFS_CMP_A_EXT, {9'h000, ea});
      rchk(OFS_CMP_B_EXT, {9'h000, eb});
      tgt = i[0] ? {eb[0], ab} : {ea[0], aa};
      repeat (40) @(posedge clk);
      // end-trace reset keeps the compare setup only when armed and not begin-triggered
      k = 1'($urandom);
      busy = 1;
      rst <= 1; etr <= k;
      @(posedge clk);
      rst <= 0; etr <= 0;
      if (!(k && md[MODE_DEBUGGER_ENABLE_BIT] && !md[MODE_BEGIN_BIT])) {ea, eb, aa, ab} = '0;
      md = MODE_RESET;
      @(posedge clk);
      busy = 0;
      rchk(OFS_CMP_A_EXT, {9'h000, ea});
      rchk(OFS_CMP_B_EXT, {9'h000, eb});
      rchk(OFS_CMP_A_ADDR, {1'b0, aa});
      repeat (10) @(posedge clk);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
